/* core/pobs_map.svh */
// constants and reference codes for the power-on / brownout flag sequencer
// assumes a 250 MHz clock and comparator inputs from the analogue side
`ifndef POBS_MAP_SVH
`define POBS_MAP_SVH
`define POBS_CLK_MHZ       250
`define POBS_STARTUP_US    100
`define POBS_BROWNOUT_US   25
`define POBS_OVERRANGE_US  3
`define POBS_CNT_W         16
`define POBS_REF_2V5       2'h0
`define POBS_REF_1V65      2'h1
`define POBS_REF_HALF_VS   2'h2
`endif

/* core/pobs_pkg.sv */
// types for the power-on / brownout flag sequencer
// assumes nothing beyond the constants header
package pobs_pkg;
  typedef enum logic [1:0] {
    POBS_ST_RESET   = 2'b00,
    POBS_ST_STARTUP = 2'b01,
    POBS_ST_RUN     = 2'b10
  } pobs_state_t;
endpackage

/* core/pobs_sequencer.sv */
// supervisory sequencer: power-on, brownout filter, flags, reference decode
// assumes comparator levels arrive asynchronously from the analogue side
`include "pobs_map.svh"
`timescale 1ns/10ps
`default_nettype none
module pobs_sequencer #(
  parameter int STARTUP_CYC   = `POBS_STARTUP_US * `POBS_CLK_MHZ,
  parameter int BROWNOUT_CYC  = `POBS_BROWNOUT_US * `POBS_CLK_MHZ,
  parameter int OVERRANGE_CYC = `POBS_OVERRANGE_US * `POBS_CLK_MHZ
) (
  // clock and reset
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_I,
  // supply comparators
  input  wire logic       SUPPLY_OK_I,
  input  wire logic       SUPPLY_DEEP_DIP_I,
  // analogue fault indications
  input  wire logic       AMP_OVERLOAD_I,
  input  wire logic       SENSOR_FAULT_I,
  // select pins
  input  wire logic       REF_SELECT_B1_I,
  input  wire logic       REF_SELECT_B2_I,
  input  wire logic       GAIN_SELECT_B1_I,
  input  wire logic       GAIN_SELECT_B2_I,
  // outputs
  output logic            COIL_DRIVE_ENABLE_O,
  output logic            SENSE_OUTPUT_VALID_O,
  output logic [1:0]      REF_MODE_O,
  output logic            ERROR_N_O,
  output logic            ERROR_N_OE_O,
  output logic            OVERRANGE_N_O,
  output logic            OVERRANGE_N_OE_O,
  output logic            POR_ACTIVE_O
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [7:0] s1_r, s2_r;
  logic [7:0] raw;
  assign raw = {GAIN_SELECT_B2_I, GAIN_SELECT_B1_I, REF_SELECT_B2_I, REF_SELECT_B1_I,
                SENSOR_FAULT_I, AMP_OVERLOAD_I, SUPPLY_DEEP_DIP_I, SUPPLY_OK_I};
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  logic sup_ok, deep_dip, ovl, fault, rs1, rs2, gs1, gs2;
  assign {gs2, gs1, rs2, rs1, fault, ovl, deep_dip, sup_ok} = s2_r;

  // ************************************************************
  // sequencer state and counters
  // ************************************************************
  pobs_pkg::pobs_state_t   st_r, st_nxt;
  logic [`POBS_CNT_W-1:0]  su_cnt_r, su_cnt_nxt;
  logic [`POBS_CNT_W-1:0]  bo_cnt_r, bo_cnt_nxt;
  logic [`POBS_CNT_W-1:0]  or_cnt_r, or_cnt_nxt;
  logic                    or_flag_r, or_flag_nxt;
  logic                    err_r, err_nxt;
  logic                    coil_en_r, coil_en_nxt;
  logic                    valid_r, valid_nxt;
  logic                    por_r, por_nxt;
  logic                    brownout_reset;
  logic                    supply_lost;

  // filter: a drop must outlast the window before it counts
  assign brownout_reset = !sup_ok && (bo_cnt_r >= `POBS_CNT_W'(BROWNOUT_CYC));
  // deep dip bypasses the filter entirely
  assign supply_lost    = deep_dip || brownout_reset;

  // ************************************************************
  // brownout duration filter
  // ************************************************************
  always_comb begin
    bo_cnt_nxt = bo_cnt_r;
    // saturates at the window so a long drop cannot wrap under it
    if (sup_ok || st_r == pobs_pkg::POBS_ST_RESET) begin
      bo_cnt_nxt = '0;
    end else if (bo_cnt_r < `POBS_CNT_W'(BROWNOUT_CYC)) begin
      bo_cnt_nxt = bo_cnt_r + `POBS_CNT_W'(1);
    end
  end
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bo_cnt_r <= '0;
    end else begin
      bo_cnt_r <= bo_cnt_nxt;
    end
  end

  // ************************************************************
  // power-on state machine
  // ************************************************************
  always_comb begin
    st_nxt     = st_r;
    su_cnt_nxt = su_cnt_r;
    case (st_r)
      pobs_pkg::POBS_ST_RESET: begin
        su_cnt_nxt = '0;
        if (sup_ok && !deep_dip) begin
          st_nxt = pobs_pkg::POBS_ST_STARTUP;
        end
      end
      pobs_pkg::POBS_ST_STARTUP: begin
        if (su_cnt_r >= `POBS_CNT_W'(STARTUP_CYC - 1)) begin
          st_nxt = pobs_pkg::POBS_ST_RUN;
        end else begin
          su_cnt_nxt = su_cnt_r + `POBS_CNT_W'(1);
        end
      end
      pobs_pkg::POBS_ST_RUN: begin
        su_cnt_nxt = su_cnt_r;
      end
      default: begin
        st_nxt = pobs_pkg::POBS_ST_RESET;
      end
    endcase
    if (supply_lost) begin
      st_nxt = pobs_pkg::POBS_ST_RESET;
    end
  end
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r     <= pobs_pkg::POBS_ST_RESET;
      su_cnt_r <= '0;
    end else begin
      st_r     <= st_nxt;
      su_cnt_r <= su_cnt_nxt;
    end
  end

  // ************************************************************
  // overrange persistence
  // ************************************************************
  always_comb begin
    or_cnt_nxt  = or_cnt_r;
    or_flag_nxt = or_flag_r;
    // released at once when overload ends, no hold-off on release
    if (!ovl) begin
      or_cnt_nxt  = '0;
      or_flag_nxt = 1'b0;
    end else if (or_cnt_r >= `POBS_CNT_W'(OVERRANGE_CYC - 1)) begin
      or_flag_nxt = 1'b1;
    end else begin
      or_cnt_nxt = or_cnt_r + `POBS_CNT_W'(1);
    end
  end
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      or_cnt_r  <= '0;
      or_flag_r <= 1'b0;
    end else begin
      or_cnt_r  <= or_cnt_nxt;
      or_flag_r <= or_flag_nxt;
    end
  end

  // ************************************************************
  // error flag
  // ************************************************************
  // forced outside run, else follows the live fault; op-amp mode masks it
  always_comb begin
    err_nxt = ((st_nxt != pobs_pkg::POBS_ST_RUN) || fault) && !(gs1 && gs2);
  end
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      err_r <= 1'b1;
    end else begin
      err_r <= err_nxt;
    end
  end

  // ************************************************************
  // status outputs
  // ************************************************************
  // registered from the next state so they line up with st_r
  always_comb begin
    coil_en_nxt = (st_nxt == pobs_pkg::POBS_ST_RUN);
    valid_nxt   = (st_nxt == pobs_pkg::POBS_ST_RUN);
    por_nxt     = (st_nxt == pobs_pkg::POBS_ST_RESET);
  end
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      coil_en_r <= 1'b0;
      valid_r   <= 1'b0;
      por_r     <= 1'b1;
    end else begin
      coil_en_r <= coil_en_nxt;
      valid_r   <= valid_nxt;
      por_r     <= por_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic [1:0] ref_mode_nxt, ref_mode_r;
  always_comb begin
    if (rs1 && rs2) begin
      ref_mode_nxt = `POBS_REF_HALF_VS;
    end else if (rs1) begin
      ref_mode_nxt = `POBS_REF_1V65;
    end else begin
      ref_mode_nxt = `POBS_REF_2V5;
    end
  end
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ref_mode_r <= `POBS_REF_2V5;
    end else begin
      ref_mode_r <= ref_mode_nxt;
    end
  end

  // open-drain pins: only ever drive low; pull-up is the system's
  assign ERROR_N_O            = 1'b0;
  assign ERROR_N_OE_O         = err_r;
  assign OVERRANGE_N_O        = 1'b0;
  assign OVERRANGE_N_OE_O     = or_flag_r;
  assign COIL_DRIVE_ENABLE_O  = coil_en_r;
  assign SENSE_OUTPUT_VALID_O = valid_r;
  assign POR_ACTIVE_O         = por_r;
  assign REF_MODE_O           = ref_mode_r;
endmodule
`default_nettype wire

/* verif/pobs_supply_model.sv */
// supply rail and flag pull-up model
// assumes rail level given in tenths of a volt
`timescale 1ns/10ps
`default_nettype none
module pobs_supply_model (
  input  wire logic [5:0] rail_dv_i,
  input  wire logic       err_oe_i,
  input  wire logic       or_oe_i,
  output logic            ok_o,
  output logic            dip_o,
  output logic            flag_n_o
);
  assign ok_o = rail_dv_i > 6'h18;
  assign dip_o = rail_dv_i <= 6'h12;
  // shared line, pulled up, low if either drain is on
  assign flag_n_o = !(err_oe_i || or_oe_i);
endmodule
`default_nettype wire

/* verif/pobs_sequencer_assertions.sv */
// port checker for the sequencer
// assumes a bind onto pobs_sequencer
`include "pobs_map.svh"
`timescale 1ns/10ps
`default_nettype none
module pobs_sequencer_assertions #(
  parameter int STARTUP_CYC = 25000, BROWNOUT_CYC = 6250, OVERRANGE_CYC = 750
) (
  input wire logic SYS_CLK_I, RST_I, SUPPLY_OK_I, SUPPLY_DEEP_DIP_I, AMP_OVERLOAD_I,
  input wire logic REF_SELECT_B1_I, REF_SELECT_B2_I, GAIN_SELECT_B1_I, POR_ACTIVE_O,
  input wire logic COIL_DRIVE_ENABLE_O, SENSE_OUTPUT_VALID_O, ERROR_N_OE_O, OVERRANGE_N_OE_O,
  input wire logic [1:0] REF_MODE_O
);
  logic [15:0] st_r, lo_r, ov_r;
  logic [1:0]  ref_exp;
  // pins 01 fall back to 2.5 V
  assign ref_exp = !REF_SELECT_B1_I ? `POBS_REF_2V5 :
                   REF_SELECT_B2_I ? `POBS_REF_HALF_VS : `POBS_REF_1V65;
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r <= 16'h0;
      lo_r <= 16'h0;
      ov_r <= 16'h0;
    end else begin
      st_r <= POR_ACTIVE_O ? 16'h0 : st_r + 16'(!SENSE_OUTPUT_VALID_O);
      lo_r <= SUPPLY_OK_I ? 16'h0 : lo_r + 16'h1;
      ov_r <= AMP_OVERLOAD_I ? ov_r + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  AST_STARTUP: assert property ($rose(SENSE_OUTPUT_VALID_O) |-> st_r >= STARTUP_CYC)
    else $error("startup too short");
  AST_COIL: assert property ($fell(POR_ACTIVE_O) |-> !COIL_DRIVE_ENABLE_O [*8])
    else $error("coil driven in startup");
  AST_ERR: assert property (!GAIN_SELECT_B1_I [*4] ##0 !SENSE_OUTPUT_VALID_O |-> ERROR_N_OE_O)
    else $error("error flag not forced");
  AST_OR_SET: assert property ($rose(OVERRANGE_N_OE_O) |-> ov_r >= OVERRANGE_CYC + 1)
    else $error("overrange too early");
  AST_OR_CLR: assert property ($fell(AMP_OVERLOAD_I) |-> ##[1:4] !OVERRANGE_N_OE_O)
    else $error("overrange not released");
  AST_DIP: assert property (SUPPLY_DEEP_DIP_I |-> ##[1:4] POR_ACTIVE_O)
    else $error("deep dip missed");
  AST_BO_LONG: assert property (lo_r == BROWNOUT_CYC + 4 |-> POR_ACTIVE_O)
    else $error("brownout missed");
  AST_BO_SHORT: assert property ($rose(POR_ACTIVE_O) |-> lo_r >= BROWNOUT_CYC || SUPPLY_DEEP_DIP_I)
    else $error("short drop reset");
  AST_REF: assert property ($stable({REF_SELECT_B1_I, REF_SELECT_B2_I}) [*4] |-> REF_MODE_O == ref_exp)
    else $error("bad reference mode");
  cover property ($rose(SENSE_OUTPUT_VALID_O));
  cover property ($rose(OVERRANGE_N_OE_O));
  cover property ($rose(POR_ACTIVE_O));
endmodule
bind pobs_sequencer pobs_sequencer_assertions #(
  .STARTUP_CYC(STARTUP_CYC), .BROWNOUT_CYC(BROWNOUT_CYC), .OVERRANGE_CYC(OVERRANGE_CYC)
) chk (.*);
`default_nettype wire

/* verif/pobs_sequencer_tb_top.sv */
// bench for the sequencer, short counts
// assumes inputs change at the falling edge
`timescale 1ns/10ps
`default_nettype none
module pobs_sequencer_tb_top;
  logic clk = 0, rst = 1, ovl = 0, flt = 0, r1 = 0, r2 = 0, g1 = 0, g2 = 0;
  logic [5:0] rail = 6'h21;
  logic [3:0] rows [4] = '{4'h0, 4'h9, 4'hE, 4'h4};
  wire logic ok, dip, coil, vld, eoe, ooe, por, flag_n, epin, opin;
  wire logic [1:0] mode;
  int bad_count = 0, n_checks = 0;
  always #2 clk = ~clk;
  pobs_sequencer #(.STARTUP_CYC(20), .BROWNOUT_CYC(8), .OVERRANGE_CYC(4)) DUT (
    .SYS_CLK_I(clk), .RST_I(rst), .SUPPLY_OK_I(ok), .SUPPLY_DEEP_DIP_I(dip),
    .AMP_OVERLOAD_I(ovl), .SENSOR_FAULT_I(flt), .REF_SELECT_B1_I(r1), .REF_SELECT_B2_I(r2),
    .GAIN_SELECT_B1_I(g1), .GAIN_SELECT_B2_I(g2), .COIL_DRIVE_ENABLE_O(coil),
    .SENSE_OUTPUT_VALID_O(vld), .REF_MODE_O(mode), .ERROR_N_O(epin), .ERROR_N_OE_O(eoe),
    .OVERRANGE_N_O(opin), .OVERRANGE_N_OE_O(ooe), .POR_ACTIVE_O(por));
  pobs_supply_model MDL (.rail_dv_i(rail), .err_oe_i(eoe), .or_oe_i(ooe),
    .ok_o(ok), .dip_o(dip), .flag_n_o(flag_n));
  task automatic chk(input logic [3:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    w(6);
    rst = 0;
    w(10);
    chk({coil, vld, flag_n}, 4'h0);
    w(20);
    chk({coil, vld, flag_n}, 4'h7);
    foreach (rows[i]) begin
      {r1, r2} = rows[i][3:2];
      w(5);
      chk(mode, rows[i][1:0]);
    end
    flt = 1;
    w(5);
    chk(flag_n, 4'h0);
    {g1, g2} = 2'h3;
    w(5);
    chk(flag_n, 4'h1);
    {g1, g2, flt} = 3'h0;
    w(5);
    chk(flag_n, 4'h1);
    ovl = 1;
    w(3);
    ovl = 0;
    w(5);
    chk(flag_n, 4'h1);
    ovl = 1;
    w(9);
    chk(flag_n, 4'h0);
    ovl = 0;
    w(4);
    chk(flag_n, 4'h1);
    // drop shorter than the window must be ridden out
    rail = 6'h16;
    w(5);
    rail = 6'h21;
    w(5);
    chk({por, vld}, 4'h1);
    rail = 6'h16;
    w(14);
    chk({por, coil, flag_n}, 4'h4);
    rail = 6'h21;
    w(30);
    chk(vld, 4'h1);
    rail = 6'h0F;
    w(4);
    chk({por, coil}, 4'h2);
    rail = 6'h21;
    w(30);
    chk(vld, 4'h1);
    chk({epin, opin}, 4'h0);
    // reset in mid-run: outputs fall back at once, full startup follows
    rst = 1;
    w(2);
    chk({por, coil, vld, flag_n}, 4'h8);
    rst = 0;
    w(10);
    chk({por, vld, flag_n}, 4'h0);
    w(20);
    chk({por, vld, flag_n}, 4'h3);
    wrap_up;
  end
  initial begin
    w(600);
    bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
